/* include/frtc_pkg.sv */
// Constants shared by the free-running timer and capture block.
// Assumes a single 100 MHz bus clock and byte-wide registers in 32-bit words.
`default_nettype none
package frtc_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_CNT_LO = 8'h20;
   localparam logic [7:0] IDX_CNT_HI = 8'h21;
   localparam logic [7:0] IDX_C0_RISE = 8'h22;
   localparam logic [7:0] IDX_C1_RISE = 8'h23;
   localparam logic [7:0] IDX_C0_FALL = 8'h24;
   localparam logic [7:0] IDX_C1_FALL = 8'h25;
   localparam logic [7:0] IDX_CONFIG = 8'h2a;
   localparam logic [7:0] IDX_STATUS = 8'h2c;

   // Capture slots in status-bit order: ch0 rise, ch0 fall, ch1 rise, ch1 fall
   localparam int NUM_CAP = 4;
   localparam logic [7:0] CAP_IDX [NUM_CAP] = '{IDX_C0_RISE, IDX_C0_FALL, IDX_C1_RISE, IDX_C1_FALL};
   localparam int SLOT_C0_RISE = 0;
   localparam int SLOT_C0_FALL = 1;
   localparam int SLOT_C1_RISE = 2;
   localparam int SLOT_C1_FALL = 3;

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------
   localparam int CFG_HOLD_BIT = 7;
   localparam int CFG_SEL_HI = 6;
   localparam int CFG_SEL_LO = 4;
   localparam int CFG_WIDE_BIT = 3;
   localparam logic [7:0] CFG_WR_MASK = 8'hf8;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // Periodic tick: 1024 us at a 4 MHz timebase
   // ------------------------------------------------------------
   localparam int PERIOD_US = 1024;
   localparam int TIMEBASE_MHZ = 4;
   localparam int PERIOD_TICKS = PERIOD_US * TIMEBASE_MHZ;
   localparam int PERIOD_BITS = $clog2(PERIOD_TICKS);

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

/* src/frtc_edge.sv */
// Two-stage synchroniser with rise and fall pulse detection.
// Assumes the input toggles slower than half the bus clock.
`timescale 1ns/1ps
`default_nettype none
module frtc_edge (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin_in,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // ------------------------------------------------------------
   // Synchroniser and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Only the second stage and its delayed copy feed the detector
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule
`default_nettype wire

/* src/frtc_capreg.sv */
// One 8-bit capture register with first-edge hold and a sticky status flag.
// Assumes load, read and clear strobes are single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module frtc_capreg (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic load,
   input wire logic [7:0] value,
   input wire logic hold_first,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic clr,
   output logic [7:0] data_r,
   output logic flag_r
);
   logic loaded_r;
   logic accept;

   // Held value blocks later edges until software reads it
   assign accept = load & ~(hold_first & loaded_r);

   // ------------------------------------------------------------
   // Data
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_r <= frtc_pkg::BYTE_RESET;
      end else if (wr) begin
         data_r <= wdata;
      end else if (accept) begin
         data_r <= value;
      end
   end

   // Load wins over a read in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loaded_r <= 1'b0;
      end else if (accept) begin
         loaded_r <= 1'b1;
      end else if (rd) begin
         loaded_r <= 1'b0;
      end
   end

   // Set wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= 1'b0;
      end else if (accept) begin
         flag_r <= 1'b1;
      end else if (clr) begin
         flag_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* src/frtc_top.sv */
// Free-running 16-bit timer with two 8-bit edge-capture channels, AHB-Lite slave.
// Assumes the timebase and capture pins change slower than half of hclk.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 16-bit counter advances on each timebase clock rising edge; software can read it.
// - Timebase and bus accesses are brought together safely in one clock domain.
// - Reading low byte snapshots the high byte for an atomic 16-bit read.
// - Low byte write is held pending; high byte write loads all 16 bits.
// - Periodic interrupt every 1024 us with a 4 MHz timebase.
// - Separate interrupt when the counter wraps past its maximum.
// - Channel 0 rising edge loads the channel 0 rising register.
// - Channel 0 falling edge loads the channel 0 falling register.
// - In 8-bit mode channel 1 rising edge loads its rising register.
// - In 8-bit mode channel 1 falling edge loads its falling register.
// - In 8-bit mode the window select picks which counter bits are stored.
// - In 16-bit mode channel 0 rising stores low and high bytes together.
// - In 16-bit mode channel 0 falling stores low and high bytes together.
// - Window codes 0 to 7 select counter bits [7:0] up to [14:7].
// - With hold set, a loaded register ignores edges until read.
// - Wide enable turns channel 1 into the upper byte of channel 0.
// - Each load sets a status flag; writing one clears it.
module frtc_top #(
   parameter int ADDR_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic capture_timebase_clock,
   input wire logic capture_input_0,
   input wire logic capture_input_1,
   output logic periodic_irq,
   output logic overflow_irq,
   output logic capture_irq
);
   localparam int NC = frtc_pkg::NUM_CAP;

   logic [15:0] count_r;
   logic [7:0] hold_hi_r;
   logic [7:0] pend_lo_r;
   logic [7:0] cfg_r;
   logic [31:0] hrdata_r;
   logic dph_wr_r;
   logic [7:0] dph_idx_r;
   logic periodic_r;
   logic overflow_r;

   logic tick;
   logic rise0, fall0, rise1, fall1;
   logic ap_valid;
   logic [7:0] ap_idx;
   logic ap_rd;
   logic [7:0] wbyte;
   logic hold_first;
   logic wide;
   logic [2:0] win_sel;
   logic [15:0] shifted;
   logic [7:0] win8;
   logic [7:0] rd_mux;

   logic [NC-1:0] cap_load;
   logic [NC-1:0] cap_rd;
   logic [NC-1:0] cap_wr;
   logic [NC-1:0] cap_clr;
   logic [NC-1:0] cap_flag;
   logic [7:0] cap_val [NC];
   logic [7:0] cap_data [NC];

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Timebase rising edges become one-cycle ticks in the bus clock domain
   frtc_edge u_tb (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(capture_timebase_clock),
      .rise(tick),
      .fall()
   );

   frtc_edge u_in0 (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(capture_input_0),
      .rise(rise0),
      .fall(fall0)
   );

   frtc_edge u_in1 (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(capture_input_1),
      .rise(rise1),
      .fall(fall1)
   );

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign ap_valid = hsel & hready & (htrans == frtc_pkg::HTRANS_NONSEQ);
   assign ap_idx = haddr[9:2];
   assign ap_rd = ap_valid & ~hwrite;
   assign wbyte = hwdata[7:0];
   assign hreadyout = 1'b1;
   assign hresp = frtc_pkg::HRESP_OKAY;
   assign hrdata = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_r <= 1'b0;
         dph_idx_r <= frtc_pkg::BYTE_RESET;
      end else begin
         dph_wr_r <= ap_valid & hwrite;
         dph_idx_r <= ap_idx;
      end
   end

   // ------------------------------------------------------------
   // Configuration
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= frtc_pkg::CFG_RESET;
      end else if (dph_wr_r && dph_idx_r == frtc_pkg::IDX_CONFIG) begin
         cfg_r <= wbyte & frtc_pkg::CFG_WR_MASK;
      end
   end

   assign hold_first = cfg_r[frtc_pkg::CFG_HOLD_BIT];
   assign wide = cfg_r[frtc_pkg::CFG_WIDE_BIT];
   assign win_sel = cfg_r[frtc_pkg::CFG_SEL_HI:frtc_pkg::CFG_SEL_LO];

   // ------------------------------------------------------------
   // Free-running counter
   // ------------------------------------------------------------
   // A write of the high byte beats a tick in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= frtc_pkg::CNT_RESET;
      end else if (dph_wr_r && dph_idx_r == frtc_pkg::IDX_CNT_HI) begin
         count_r <= {wbyte, pend_lo_r};
      end else if (tick) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // Low byte waits here until the high byte arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_lo_r <= frtc_pkg::BYTE_RESET;
      end else if (dph_wr_r && dph_idx_r == frtc_pkg::IDX_CNT_LO) begin
         pend_lo_r <= wbyte;
      end
   end

   // Snapshot taken at the same edge that latches the low byte read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_hi_r <= frtc_pkg::BYTE_RESET;
      end else if (ap_rd && ap_idx == frtc_pkg::IDX_CNT_LO) begin
         hold_hi_r <= count_r[15:8];
      end
   end

   // ------------------------------------------------------------
   // Timer interrupts
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periodic_r <= 1'b0;
      end else begin
         periodic_r <= tick & (&count_r[frtc_pkg::PERIOD_BITS-1:0]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overflow_r <= 1'b0;
      end else begin
         overflow_r <= tick & (&count_r);
      end
   end

   assign periodic_irq = periodic_r;
   assign overflow_irq = overflow_r;
   assign capture_irq = |cap_flag;

   // ------------------------------------------------------------
   // Capture routing
   // ------------------------------------------------------------
   assign shifted = count_r >> win_sel;
   assign win8 = shifted[7:0];

   always_comb begin
      cap_load[frtc_pkg::SLOT_C0_RISE] = rise0;
      cap_load[frtc_pkg::SLOT_C0_FALL] = fall0;
      cap_val[frtc_pkg::SLOT_C0_RISE] = wide ? count_r[7:0] : win8;
      cap_val[frtc_pkg::SLOT_C0_FALL] = wide ? count_r[7:0] : win8;
      if (wide) begin
         // Channel 1 pins ignored; its registers take the upper byte
         cap_load[frtc_pkg::SLOT_C1_RISE] = rise0;
         cap_load[frtc_pkg::SLOT_C1_FALL] = fall0;
         cap_val[frtc_pkg::SLOT_C1_RISE] = count_r[15:8];
         cap_val[frtc_pkg::SLOT_C1_FALL] = count_r[15:8];
      end else begin
         cap_load[frtc_pkg::SLOT_C1_RISE] = rise1;
         cap_load[frtc_pkg::SLOT_C1_FALL] = fall1;
         cap_val[frtc_pkg::SLOT_C1_RISE] = win8;
         cap_val[frtc_pkg::SLOT_C1_FALL] = win8;
      end
   end

   // ------------------------------------------------------------
   // Capture registers
   // ------------------------------------------------------------
   for (genvar i = 0; i < NC; i++) begin : g_cap
      assign cap_rd[i] = ap_rd & (ap_idx == frtc_pkg::CAP_IDX[i]);
      assign cap_wr[i] = dph_wr_r & (dph_idx_r == frtc_pkg::CAP_IDX[i]);
      assign cap_clr[i] = dph_wr_r & (dph_idx_r == frtc_pkg::IDX_STATUS) & wbyte[i];

      frtc_capreg u_cap (
         .hclk(hclk),
         .hresetn(hresetn),
         .load(cap_load[i]),
         .value(cap_val[i]),
         .hold_first(hold_first),
         .rd(cap_rd[i]),
         .wr(cap_wr[i]),
         .wdata(wbyte),
         .clr(cap_clr[i]),
         .data_r(cap_data[i]),
         .flag_r(cap_flag[i])
      );
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb begin
      rd_mux = frtc_pkg::BYTE_RESET;
      if (ap_idx == frtc_pkg::IDX_CNT_LO) begin
         rd_mux = count_r[7:0];
      end else if (ap_idx == frtc_pkg::IDX_CNT_HI) begin
         rd_mux = hold_hi_r;
      end else if (ap_idx == frtc_pkg::IDX_CONFIG) begin
         rd_mux = cfg_r;
      end else if (ap_idx == frtc_pkg::IDX_STATUS) begin
         rd_mux = {4'h0, cap_flag};
      end else begin
         for (int k = 0; k < NC; k++) begin
            if (ap_idx == frtc_pkg::CAP_IDX[k]) begin
               rd_mux = cap_data[k];
            end
         end
      end
   end

   // Read data registered at the address phase, so no wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= frtc_pkg::RDATA_RESET;
      end else if (ap_rd) begin
         hrdata_r <= {24'h000000, rd_mux};
      end
   end
endmodule
`default_nettype wire

/* sim/frtc_pins_model.sv */
// Model of the pins around the block: timebase clock and two capture inputs.
// Assumes it shares hclk with the bench; changes land just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module frtc_pins_model (
   input wire logic hclk,
   output logic tbase_clk,
   output logic pin0,
   output logic pin1
);
   // ----
   // Drivers
   // ----
   initial begin
      tbase_clk = 1'b0;
      pin0 = 1'b0;
      pin1 = 1'b0;
   end
   // Exact tick count; clock stands low between bursts so counts stay known
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         tbase_clk <= 1'b1;
         repeat (4) @(posedge hclk);
         tbase_clk <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask
   // Six cycles cover sync and edge latency
   task automatic set_pin(input int ch, input logic b);
      @(posedge hclk);
      if (ch == 0) pin0 <= b;
      else pin1 <= b;
      repeat (6) @(posedge hclk);
   endtask
endmodule
`default_nettype wire

/* sim/frtc_assertions.sv */
// Checker for the timer block: bus answer, interrupt pulses, flag causes.
// Assumes it is bound to frtc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module frtc_checker #(
   parameter int ADDR_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic capture_input_0,
   input wire logic capture_input_1,
   input wire logic periodic_irq,
   input wire logic overflow_irq,
   input wire logic capture_irq
);
   // ----
   // Helpers
   // ----
   logic take;
   logic st_wr_r;
   logic st_rd_r;
   logic [1:0] pin_r;
   logic [7:0] chg_r;
   assign take = hsel && hready && htrans == frtc_pkg::HTRANS_NONSEQ && haddr[9:2] == frtc_pkg::IDX_STATUS;
   // Window of eight cycles covers the sync and edge latency
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_wr_r <= 1'b0;
         st_rd_r <= 1'b0;
         pin_r <= 2'h0;
         chg_r <= 8'h00;
      end else begin
         st_wr_r <= take && hwrite;
         st_rd_r <= take && !hwrite;
         pin_r <= {capture_input_1, capture_input_0};
         chg_r <= {chg_r[6:0], |(pin_r ^ {capture_input_1, capture_input_0})};
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   AST_RESP_OKAY: assert property (hresp == frtc_pkg::HRESP_OKAY)
      else $error("hresp not okay");
   AST_NO_WAIT: assert property (hreadyout)
      else $error("wait state seen");
   AST_RDATA_BYTE: assert property (hrdata[31:8] == 24'h0)
      else $error("hrdata upper bits set");
   AST_PER_PULSE: assert property (periodic_irq |=> !periodic_irq)
      else $error("periodic pulse too long");
   AST_OVF_PULSE: assert property (overflow_irq |=> !overflow_irq [*2])
      else $error("overflow pulse too long");
   AST_OVF_WITH_PER: assert property (overflow_irq |-> periodic_irq)
      else $error("overflow without periodic");
   AST_CAP_CAUSE: assert property ($rose(capture_irq) |-> |chg_r)
      else $error("flag without pin edge");
   AST_FLAG_CLEAR: assert property ($fell(capture_irq) |-> $past(st_wr_r))
      else $error("flag fell without clear");
   AST_STAT_RSVD: assert property (st_rd_r |-> hrdata[7:4] == 4'h0)
      else $error("status reserved bits set");
   cover property (overflow_irq);
   cover property ($rose(capture_irq));
   cover property ($fell(capture_irq));
endmodule
bind frtc_top frtc_checker #(.ADDR_W(ADDR_W)) frtc_checker_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .capture_input_0(capture_input_0), .capture_input_1(capture_input_1),
   .periodic_irq(periodic_irq), .overflow_irq(overflow_irq), .capture_irq(capture_irq)
);
`default_nettype wire

/* sim/free_running_timer_capture_tb.sv */
// Bench for the timer block: AHB-Lite tasks and directed register tests.
// Assumes the design, checker and pin model are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module free_running_timer_capture_tb;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hready;
   logic hresp;
   logic [31:0] hrdata;
   logic tclk;
   logic pin0;
   logic pin1;
   logic per_irq;
   logic ovf_irq;
   logic cap_irq;
   logic [7:0] per_cnt;
   logic [7:0] ovf_cnt;
   logic [7:0] v;
   int error_cnt;
   int comparisons;
   int cyc;
   frtc_top frtc_top_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .capture_timebase_clock(tclk), .capture_input_0(pin0),
      .capture_input_1(pin1), .periodic_irq(per_irq), .overflow_irq(ovf_irq), .capture_irq(cap_irq)
   );
   frtc_pins_model frtc_pins_model_inst (.hclk(hclk), .tbase_clk(tclk), .pin0(pin0), .pin1(pin1));
   // ----
   // Tasks
   // ----
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   // Idle cycle between transfers avoids the read-after-write hazard
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= frtc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {2'h0, idx, 2'h0};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, idx, d, x);
   endtask
   task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] x;
      bus(1'b0, idx, 8'h00, x);
      chk(nm, exp, x);
   endtask
   task automatic set_cnt(input logic [15:0] c);
      wr(frtc_pkg::IDX_CNT_LO, c[7:0]);
      wr(frtc_pkg::IDX_CNT_HI, c[15:8]);
   endtask
   task automatic pin(input int ch, input logic b);
      frtc_pins_model_inst.set_pin(ch, b);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----
   // Clock, monitors, tests
   // ----
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (per_irq === 1'b1) per_cnt <= per_cnt + 8'h01;
      if (ovf_irq === 1'b1) ovf_cnt <= ovf_cnt + 8'h01;
      if (cyc == 20000) begin
         error_cnt++;
         final_report;
      end
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      error_cnt = 0;
      comparisons = 0;
      cyc = 0;
      per_cnt = 8'h00;
      ovf_cnt = 8'h00;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd("reset", frtc_pkg::IDX_CNT_LO + 8'(i), 8'h00);
      rd("status", frtc_pkg::IDX_STATUS, 8'h00);
      wr(8'h30, 8'hff);
      rd("unmapped", 8'h30, 8'h00);
      wr(frtc_pkg::IDX_CONFIG, 8'hff);
      rd("config", frtc_pkg::IDX_CONFIG, frtc_pkg::CFG_WR_MASK);
      $display("test reset done");
      wr(frtc_pkg::IDX_CNT_LO, 8'h34);
      rd("pending", frtc_pkg::IDX_CNT_LO, 8'h00);
      wr(frtc_pkg::IDX_CNT_HI, 8'h12);
      rd("cnt_lo", frtc_pkg::IDX_CNT_LO, 8'h34);
      rd("cnt_hi", frtc_pkg::IDX_CNT_HI, 8'h12);
      set_cnt(16'h12ff);
      rd("snap_lo", frtc_pkg::IDX_CNT_LO, 8'hff);
      frtc_pins_model_inst.ticks(2);
      rd("snap_hi", frtc_pkg::IDX_CNT_HI, 8'h12);
      rd("run_lo", frtc_pkg::IDX_CNT_LO, 8'h01);
      rd("run_hi", frtc_pkg::IDX_CNT_HI, 8'h13);
      set_cnt(16'hfffe);
      frtc_pins_model_inst.ticks(2);
      chk("ovf", 8'h01, ovf_cnt);
      chk("per", 8'h01, per_cnt);
      set_cnt(16'h0ffe);
      frtc_pins_model_inst.ticks(2);
      chk("ovf", 8'h01, ovf_cnt);
      chk("per", 8'h02, per_cnt);
      $display("test counter done");
      for (int s = 0; s < 8; s++) begin
         wr(frtc_pkg::IDX_CONFIG, 8'(s << 4));
         set_cnt(16'hb5a7);
         pin(0, 1'b1);
         pin(1, 1'b1);
         set_cnt(16'h4a58);
         pin(0, 1'b0);
         pin(1, 1'b0);
         v = 8'(16'hb5a7 >> s);
         rd("c0r", frtc_pkg::IDX_C0_RISE, v);
         rd("c1r", frtc_pkg::IDX_C1_RISE, v);
         v = 8'(16'h4a58 >> s);
         rd("c0f", frtc_pkg::IDX_C0_FALL, v);
         rd("c1f", frtc_pkg::IDX_C1_FALL, v);
         chk("irq", 8'h01, {7'h0, cap_irq});
         rd("stat", frtc_pkg::IDX_STATUS, 8'h0f);
         wr(frtc_pkg::IDX_STATUS, 8'h05);
         rd("stat", frtc_pkg::IDX_STATUS, 8'h0a);
         wr(frtc_pkg::IDX_STATUS, 8'h0a);
         rd("stat", frtc_pkg::IDX_STATUS, 8'h00);
         chk("irq", 8'h00, {7'h0, cap_irq});
      end
      $display("test window done");
      wr(frtc_pkg::IDX_CONFIG, 8'h08);
      set_cnt(16'h4c3d);
      pin(1, 1'b1);
      pin(1, 1'b0);
      rd("stat", frtc_pkg::IDX_STATUS, 8'h00);
      pin(0, 1'b1);
      set_cnt(16'h9e8f);
      pin(0, 1'b0);
      rd("w0r", frtc_pkg::IDX_C0_RISE, 8'h3d);
      rd("w1r", frtc_pkg::IDX_C1_RISE, 8'h4c);
      rd("w0f", frtc_pkg::IDX_C0_FALL, 8'h8f);
      rd("w1f", frtc_pkg::IDX_C1_FALL, 8'h9e);
      $display("test wide done");
      for (int h = 0; h < 2; h++) begin
         wr(frtc_pkg::IDX_CONFIG, {h[0], 7'h0});
         for (int k = 1; k < 3; k++) begin
            set_cnt(16'(k * 16'h0011));
            pin(0, 1'b1);
            pin(0, 1'b0);
         end
         rd("hold", frtc_pkg::IDX_C0_RISE, (h == 1) ? 8'h11 : 8'h22);
      end
      set_cnt(16'h0033);
      pin(0, 1'b1);
      pin(0, 1'b0);
      rd("rearm", frtc_pkg::IDX_C0_RISE, 8'h33);
      $display("test hold done");
      wr(frtc_pkg::IDX_C1_FALL, 8'h5a);
      rd("capwr", frtc_pkg::IDX_C1_FALL, 8'h5a);
      // Mid-run reset: counter, holding byte, captures and flags are all non-zero here
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd("rst_hold", frtc_pkg::IDX_CNT_HI, 8'h00);
      for (int i = 0; i < 6; i++) rd("rst_run", frtc_pkg::IDX_CNT_LO + 8'(i), 8'h00);
      rd("rst_stat", frtc_pkg::IDX_STATUS, 8'h00);
      chk("rst_irq", 8'h00, {7'h0, cap_irq});
      $display("test reset again done");
      final_report;
   end
endmodule
`default_nettype wire
